// ### core/adcs_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_ctrl #(
  parameter int RES_W = adcs_pkg::RES_W,
  parameter int FIFO_DEPTH = adcs_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Serial port
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic frame_sync,
  output logic sdo,
  output logic sdo_oe,
  // Conversion control
  input wire logic async_conv_start_n,
  output logic eoc_n,
  // Analog front end
  input wire logic cmp_in,
  output logic [3:0] mux_sel,
  output logic sh_hold,
  output logic [RES_W-1:0] sar_code,
  // Status
  output logic [RES_W-1:0] result,
  output logic [$clog2(FIFO_DEPTH):0] fifo_level
);
  localparam int WW = adcs_pkg::WORD_W;
  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  // The bench sclk is only 8 mclk periods long, so filtering is a
  // two-sample agreement and not a longer debounce.
  wire [5:0] pin_raw = {cmp_in, async_conv_start_n, frame_sync, sdi, sclk, cs_n};
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] s3_q;
  logic [5:0] filt_q;
  wire [5:0] filt_d;
  genvar gi;
  generate
    for (gi = 0; gi < adcs_pkg::PIN_N; gi++) begin : g_sync
      assign filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          s1_q[gi] <= adcs_pkg::PIN_RST[gi];
          s2_q[gi] <= adcs_pkg::PIN_RST[gi];
          s3_q[gi] <= adcs_pkg::PIN_RST[gi];
          filt_q[gi] <= adcs_pkg::PIN_RST[gi];
        end else if (clk_en) begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          filt_q[gi] <= filt_d[gi];
        end
      end
    end
  endgenerate
  wire [5:0] rise = filt_d & ~filt_q;
  wire [5:0] fall = ~filt_d & filt_q;
  wire cs_fall = fall[adcs_pkg::PIN_CS];
  wire cs_rise = rise[adcs_pkg::PIN_CS];
  wire cs_low = ~filt_q[adcs_pkg::PIN_CS];
  wire sclk_rise = rise[adcs_pkg::PIN_SCLK];
  wire sclk_fall = fall[adcs_pkg::PIN_SCLK];
  wire sdi_lvl = filt_q[adcs_pkg::PIN_SDI];
  wire fs_lvl = filt_q[adcs_pkg::PIN_FS];
  wire fs_fall = fall[adcs_pkg::PIN_FS];
  wire fs_rise = rise[adcs_pkg::PIN_FS];
  wire cst_fall = fall[adcs_pkg::PIN_CST];
  wire cst_rise = rise[adcs_pkg::PIN_CST];
  wire cmp_lvl = filt_q[adcs_pkg::PIN_CMP];
  // ******************************************************************
  // Registers
  // ******************************************************************
  adcs_pkg::adcs_state_t state_q;
  logic [3:0] cnt_q;
  logic done_q;
  logic sdi_en_q;
  logic fs_mode_q;
  logic [WW-1:0] in_q;
  logic [WW-1:0] out_q;
  logic sdo_q;
  logic sdo_oe_q;
  logic eoc_n_q;
  logic cfg_long_q;
  logic cfg_int_q;
  logic cfg_fifo_q;
  logic [3:0] chan_q;
  logic [3:0] mux_q;
  logic hold_q;
  logic async_q;
  logic [4:0] win_q;
  logic [3:0] step_q;
  logic [RES_W-1:0] sar_q;
  logic [RES_W-1:0] code_d;
  logic [RES_W-1:0] last_q;
  adcs_fifo_if #(.W(RES_W), .DEPTH(FIFO_DEPTH)) fif ();
  adcs_result_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .f(fif.store)
  );
  // ******************************************************************
  // Frame decode
  // ******************************************************************
  // Without frame sync data moves on rising sclk, with it on falling.
  wire act_edge = fs_mode_q ? sclk_fall : sclk_rise;
  wire shift_edge = sdi_en_q && !done_q && act_edge;
  wire [WW-1:0] word_d = {in_q[WW-2:0], sdi_lvl};
  wire [3:0] head_cmd = word_d[3:0];
  wire [3:0] full_cmd = word_d[WW-1:WW-adcs_pkg::CMD_W];
  wire frame_end = shift_edge && (cnt_q == adcs_pkg::EDGE_LAST);
  wire norm_start = shift_edge && (cnt_q == adcs_pkg::FOURTH_EDGE_IDX)
      && (head_cmd <= adcs_pkg::CHAN_LAST) && (state_q == adcs_pkg::ST_IDLE);
  wire [RES_W-1:0] out_res = (cfg_fifo_q && fif.pop_valid) ? fif.pop_data : last_q;
  wire [WW-1:0] out_word = {out_res, {(WW-RES_W){1'b0}}};
  wire [4:0] win_len = cfg_long_q ? adcs_pkg::WIN_LONG : adcs_pkg::WIN_SHORT;
  wire win_hit = (win_q + 5'h01) == win_len;
  wire conv_end = (state_q == adcs_pkg::ST_CONV) && sclk_rise && (step_q == 4'h0);
  wire int_set = conv_end && cfg_int_q;
  assign fif.pop_ready = frame_end && (full_cmd == adcs_pkg::CMD_FIFO_RD);
  assign fif.push_valid = conv_end && cfg_fifo_q;
  assign fif.push_data = code_d;
  // Successive approximation: a low comparator drops the trial bit.
  always_comb begin
    code_d = sar_q;
    if (!cmp_lvl) code_d[step_q] = 1'b0;
    if (step_q != 4'h0) code_d[step_q - 4'h1] = 1'b1;
  end
  // ******************************************************************
  // Serial port
  // ******************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      done_q <= 1'b0;
      sdi_en_q <= 1'b0;
      fs_mode_q <= 1'b0;
      in_q <= '0;
      out_q <= '0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall) begin
        cnt_q <= 4'h0;
        done_q <= 1'b0;
        fs_mode_q <= ~fs_lvl;
        sdi_en_q <= fs_lvl;
        sdo_oe_q <= 1'b1;
        out_q <= out_word;
        sdo_q <= out_word[WW-1];
      end else if (cs_rise) begin
        sdi_en_q <= 1'b0;
        sdo_oe_q <= 1'b0;
      end else if (fs_fall && cs_low) begin
        cnt_q <= 4'h0;
        done_q <= 1'b0;
        sdi_en_q <= 1'b1;
        out_q <= out_word;
        sdo_q <= out_word[WW-1];
      end else if (shift_edge) begin
        in_q <= word_d;
        cnt_q <= cnt_q + 4'h1;
        done_q <= (cnt_q == adcs_pkg::EDGE_LAST);
        out_q <= {out_q[WW-2:0], 1'b0};
        sdo_q <= out_q[WW-2];
      end
      // A fresh interrupt frees the data line for the new result.
      if (int_set) sdo_oe_q <= 1'b0;
    end
  end
  // ******************************************************************
  // Configuration and channel
  // ******************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_long_q <= 1'b0;
      cfg_int_q <= 1'b0;
      cfg_fifo_q <= 1'b0;
      chan_q <= adcs_pkg::CHAN_RST;
    end else if (clk_en) begin
      if (frame_end && (full_cmd == adcs_pkg::CMD_CFG_WR)) begin
        cfg_long_q <= word_d[adcs_pkg::CFG_LONG_BIT];
        cfg_int_q <= word_d[adcs_pkg::CFG_INT_BIT];
        cfg_fifo_q <= word_d[adcs_pkg::CFG_FIFO_BIT];
      end
      if (norm_start) chan_q <= head_cmd;
    end
  end
  // ******************************************************************
  // Sample and convert sequencer
  // ******************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= adcs_pkg::ST_IDLE;
      mux_q <= adcs_pkg::CHAN_RST;
      hold_q <= 1'b1;
      async_q <= 1'b0;
      win_q <= 5'h00;
      step_q <= adcs_pkg::SAR_TOP;
      sar_q <= '0;
      last_q <= '0;
      eoc_n_q <= 1'b1;
    end else if (clk_en) begin
      // Interrupt is cleared by the next frame, but a new one wins.
      if (cfg_int_q && (cs_fall || fs_rise)) eoc_n_q <= 1'b1;
      case (state_q)
        adcs_pkg::ST_IDLE: begin
          if (cst_fall) begin
            state_q <= adcs_pkg::ST_SAMPLE;
            async_q <= 1'b1;
            mux_q <= chan_q;
            hold_q <= 1'b0;
          end else if (norm_start) begin
            state_q <= adcs_pkg::ST_SAMPLE;
            async_q <= 1'b0;
            mux_q <= head_cmd;
            hold_q <= 1'b0;
            win_q <= 5'h00;
          end
        end
        adcs_pkg::ST_SAMPLE: begin
          if (async_q ? cst_rise : (sclk_rise && win_hit)) begin
            state_q <= adcs_pkg::ST_CONV;
            hold_q <= 1'b1;
            step_q <= adcs_pkg::SAR_TOP;
            sar_q <= {1'b1, {(RES_W-1){1'b0}}};
            if (!cfg_int_q) eoc_n_q <= 1'b0;
          end else if (!async_q && sclk_rise) begin
            win_q <= win_q + 5'h01;
          end
        end
        adcs_pkg::ST_CONV: begin
          if (sclk_rise) begin
            sar_q <= code_d;
            step_q <= step_q - 4'h1;
            if (step_q == 4'h0) begin
              state_q <= adcs_pkg::ST_IDLE;
              last_q <= code_d;
              eoc_n_q <= ~cfg_int_q ? 1'b1 : 1'b0;
            end
          end
        end
        default: begin
          state_q <= adcs_pkg::ST_IDLE;
          hold_q <= 1'b1;
        end
      endcase
    end
  end
  assign sdo = sdo_q;
  assign sdo_oe = sdo_oe_q;
  assign eoc_n = eoc_n_q;
  assign mux_sel = mux_q;
  assign sh_hold = hold_q;
  assign sar_code = sar_q;
  assign result = last_q;
  assign fifo_level = fif.level;
endmodule // adcs_ctrl
`default_nettype wire

// ### core/adcs_result_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_result_fifo #(
  parameter int W = adcs_pkg::RES_W,
  parameter int DEPTH = adcs_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Result stream
  adcs_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] level_q;
  wire do_push = f.push_valid && f.push_ready;
  wire do_pop = f.pop_valid && f.pop_ready;
  assign f.push_ready = (level_q != (AW+1)'(DEPTH));
  assign f.pop_valid = (level_q != '0);
  assign f.pop_data = mem[rd_ptr_q];
  assign f.level = level_q;
  always_ff @(posedge mclk) begin
    if (clk_en && do_push) begin
      mem[wr_ptr_q] <= f.push_data;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q <= '0;
    end else if (clk_en) begin
      if (do_push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (do_pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      if (do_push && !do_pop) level_q <= level_q + 1'b1;
      else if (do_pop && !do_push) level_q <= level_q - 1'b1;
    end
  end
endmodule // adcs_result_fifo
`default_nettype wire

// ### pkg/adcs_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcs_fifo_if #(
  parameter int W = 10,
  parameter int DEPTH = 8
);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic [$clog2(DEPTH):0] level;
  modport store (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data, level
  );
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data, level
  );
endinterface
`default_nettype wire

// ### pkg/adcs_pkg.sv
`default_nettype none
package adcs_pkg;
  // ******************************************************************
  // Widths and depths
  // ******************************************************************
  localparam int RES_W = 10;
  localparam int WORD_W = 16;
  localparam int CMD_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int PIN_N = 6;
  // ******************************************************************
  // Pin vector positions and levels after reset
  // ******************************************************************
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_FS = 3;
  localparam int PIN_CST = 4;
  localparam int PIN_CMP = 5;
  localparam logic [5:0] PIN_RST = 6'h19;
  // ******************************************************************
  // Frame and sampling counts
  // ******************************************************************
  localparam logic [3:0] FOURTH_EDGE_IDX = 4'h3;
  localparam logic [3:0] EDGE_LAST = 4'hF;
  localparam logic [4:0] WIN_SHORT = 5'h0C;
  localparam logic [4:0] WIN_LONG = 5'h18;
  localparam logic [3:0] SAR_TOP = 4'h9;
  // ******************************************************************
  // Commands and configuration fields
  // ******************************************************************
  localparam logic [3:0] CHAN_LAST = 4'hA;
  localparam logic [3:0] CHAN_RST = 4'h0;
  localparam logic [3:0] CMD_FIFO_RD = 4'hB;
  localparam logic [3:0] CMD_CFG_WR = 4'hE;
  localparam int CFG_LONG_BIT = 0;
  localparam int CFG_INT_BIT = 1;
  localparam int CFG_FIFO_BIT = 2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_CONV = 2'h3
  } adcs_state_t;
endpackage
`default_nettype wire

// ### sim/adcs_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************************************************
// Port checker
// ******************************************************************
module adcs_ctrl_props #(
  parameter int RES_W = adcs_pkg::RES_W,
  parameter int FIFO_DEPTH = adcs_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic frame_sync,
  input wire logic async_conv_start_n,
  // Outputs
  input wire logic sdo_oe,
  input wire logic sh_hold,
  input wire logic [3:0] mux_sel,
  input wire logic [RES_W-1:0] sar_code,
  input wire logic [RES_W-1:0] result,
  input wire logic [$clog2(FIFO_DEPTH):0] fifo_level
);
  default clocking cb @(posedge mclk); endclocking
  // A low clock enable freezes the block, so no timing promise holds then.
  default disable iff (!rst_b || !clk_en);
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  logic sclk_q;
  logic start_q;
  // Pins pass a synchroniser, so quiet time is counted on the raw pins.
  wire logic pins_moved = (sclk != sclk_q) || (async_conv_start_n != start_q);
  assign quiet_d = pins_moved ? 4'h0 : ((quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      quiet_q <= 4'h0;
      sclk_q <= 1'b0;
      start_q <= 1'b1;
    end else begin
      quiet_q <= quiet_d;
      sclk_q <= sclk;
      start_q <= async_conv_start_n;
    end
  end
  sequence s_start_low;
    $fell(async_conv_start_n) ##1 !async_conv_start_n [*7];
  endsequence
  a_reset_outputs: assert property ($rose(rst_b) |-> !sdo_oe && sh_hold)
    else $error("outputs wrong after reset");
  a_select_drive: assert property ($fell(cs_n) && frame_sync |-> ##[3:8] sdo_oe)
    else $error("output not driven after select fall");
  a_select_float: assert property (cs_n [*8] |-> !sdo_oe)
    else $error("output driven while deselected");
  a_start_sample: assert property (s_start_low |-> !sh_hold)
    else $error("start low did not sample");
  a_start_hold: assert property ($rose(async_conv_start_n) |-> ##[3:8] (sh_hold && sar_code == 10'h200))
    else $error("start rise did not hold");
  a_quiet_stable: assert property (quiet_q > 4'hA |-> $stable(sar_code) && $stable(result))
    else $error("conversion moved without serial clock");
  a_mux_range: assert property (mux_sel <= adcs_pkg::CHAN_LAST)
    else $error("channel out of range");
  a_fifo_level: assert property ($changed(fifo_level) |-> fifo_level <= FIFO_DEPTH
    && (fifo_level == $past(fifo_level) + 1'b1 || fifo_level + 1'b1 == $past(fifo_level)))
    else $error("fifo level step wrong");
endmodule // adcs_ctrl_props
`default_nettype wire

// ### sim/adcs_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************************************************
// Bench top
// ******************************************************************
module adcs_ctrl_tb_top;
  logic mclk, rst_b, clk_en, cs_n, sclk, sdi, frame_sync, start_n, sdo, sdo_oe, eoc_n, sh_hold;
  logic [3:0] mux_sel;
  logic [3:0] fifo_level;
  logic [9:0] sar_code;
  logic [9:0] result;
  logic [9:0] target;
  logic [9:0] exp_q [$];
  logic [15:0] r;
  logic hold_q;
  int rises, samp_at, hold_at, cyc, err_count, samples_checked;
  // The comparator model resolves every trial code against one fixed level.
  wire logic cmp_in = (target >= sar_code);
  adcs_host_model host_u (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .frame_sync(frame_sync), .sdo(sdo), .async_conv_start_n(start_n));
  adcs_ctrl dut_u (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .cs_n(cs_n), .sclk(sclk),
    .sdi(sdi), .frame_sync(frame_sync), .sdo(sdo), .sdo_oe(sdo_oe),
    .async_conv_start_n(start_n), .eoc_n(eoc_n), .cmp_in(cmp_in), .mux_sel(mux_sel),
    .sh_hold(sh_hold), .sar_code(sar_code), .result(result), .fifo_level(fifo_level));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // The hold state seen at each rise reflects all earlier rises.
  always @(posedge sclk) begin
    if (hold_q === 1'b1 && sh_hold === 1'b0) samp_at = rises;
    if (hold_q === 1'b0 && sh_hold === 1'b1) hold_at = rises;
    hold_q = sh_hold;
    rises = rises + 1;
  end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      conclude();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conv(input logic [3:0] ch, input int win, input logic [9:0] t);
    logic [15:0] w;
    logic o;
    w = {ch, 12'h000};
    target = t;
    if (exp_q.size() < 8) exp_q.push_back(t);
    host_u.open_f();
    check("sdo_oe", 16'(sdo_oe), 16'h0001);
    rises = 0;
    samp_at = 0;
    hold_at = 0;
    for (int i = 0; i < win + 16; i++) begin
      host_u.bit_x(w[15], o);
      w = w << 1;
    end
    host_u.close_f();
    check("samp_at", 16'(samp_at), 16'h0004);
    check("hold_at", 16'(hold_at), 16'(win + 4));
    check("mux_sel", 16'(mux_sel), 16'(ch));
    check("result", 16'(result), 16'(t));
    check("sdo_oe", 16'(sdo_oe), 16'h0000);
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk_en = 1'b1;
    rst_b = 1'b0;
    target = 10'h000;
    hold_q = 1'b1;
    {rises, samp_at, hold_at, cyc, err_count, samples_checked} = '0;
    wt(10);
    rst_b = 1'b1;
    wt(2);
    check("sdo_oe", 16'(sdo_oe), 16'h0000);
    check("eoc_n", 16'(eoc_n), 16'h0001);
    host_u.xfer({adcs_pkg::CMD_CFG_WR, 11'h002, 1'b0}, r);
    for (int ch = 0; ch <= 10; ch++) conv(4'(ch), 12, 10'h3FF - 10'(ch * 93));
    check("fifo_level", 16'(fifo_level), 16'h0008);
    for (int k = 0; k < 8; k++) begin
      host_u.xfer({adcs_pkg::CMD_FIFO_RD, 12'h000}, r);
      check("fifo_word", r, {exp_q.pop_front(), 6'h00});
    end
    check("fifo_level", 16'(fifo_level), 16'h0000);
    host_u.xfer({adcs_pkg::CMD_CFG_WR, 11'h002, 1'b1}, r);
    conv(4'h2, 24, 10'h155);
    // Extended sampling runs with select high and the serial clock still.
    // A low clock enable must hold the start edge off until it returns.
    target = 10'h0C3;
    clk_en = 1'b0;
    host_u.set_start(1'b0);
    wt(8);
    check("sh_hold", 16'(sh_hold), 16'h0001);
    clk_en = 1'b1;
    wt(8);
    check("sh_hold", 16'(sh_hold), 16'h0000);
    check("mux_sel", 16'(mux_sel), 16'h0002);
    wt(40);
    check("sh_hold", 16'(sh_hold), 16'h0000);
    host_u.set_start(1'b1);
    wt(8);
    check("sh_hold", 16'(sh_hold), 16'h0001);
    check("eoc_n", 16'(eoc_n), 16'h0000);
    host_u.tick(11);
    wt(8);
    check("result", 16'(result), 16'(target));
    check("eoc_n", 16'(eoc_n), 16'h0001);
    // In interrupt mode the line only falls once the result is ready.
    host_u.xfer({adcs_pkg::CMD_CFG_WR, 11'h003, 1'b0}, r);
    target = 10'h2B6;
    host_u.set_start(1'b0);
    wt(8);
    host_u.set_start(1'b1);
    wt(8);
    check("eoc_n", 16'(eoc_n), 16'h0001);
    host_u.tick(11);
    wt(8);
    check("eoc_n", 16'(eoc_n), 16'h0000);
    check("result", 16'(result), 16'(target));
    // A frame-sync framed read pops the oldest result and clears the interrupt.
    host_u.xfer_fs({adcs_pkg::CMD_FIFO_RD, 12'h000}, r);
    check("fifo_word", r, {exp_q.pop_front(), 6'h00});
    check("eoc_n", 16'(eoc_n), 16'h0001);
    check("fifo_level", 16'(fifo_level), 16'h0002);
    conclude();
  end
endmodule // adcs_ctrl_tb_top
bind adcs_ctrl adcs_ctrl_props #(.RES_W(RES_W), .FIFO_DEPTH(FIFO_DEPTH)) props_u (
  .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .cs_n(cs_n), .sclk(sclk), .frame_sync(frame_sync),
  .async_conv_start_n(async_conv_start_n), .sdo_oe(sdo_oe), .sh_hold(sh_hold),
  .mux_sel(mux_sel), .sar_code(sar_code), .result(result), .fifo_level(fifo_level));
`default_nettype wire

// ### sim/adcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************************************************
// Host serial port model
// ******************************************************************
module adcs_host_model (
  // Clock
  input wire logic mclk,
  // Serial port
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  output logic frame_sync,
  input wire logic sdo,
  // Conversion control
  output logic async_conv_start_n
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    frame_sync = 1'b1;
    async_conv_start_n = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic open_f();
    cs_n = 1'b0;
    wt(8);
  endtask
  // One 64 ns clock: data set mid low phase, taken on the rise.
  task automatic bit_x(input logic b, output logic o);
    wt(2);
    o = sdo;
    sdi = b;
    wt(2);
    sclk = 1'b1;
    wt(4);
    sclk = 1'b0;
  endtask
  // A released data line shows the inverse so stale bits cannot pass.
  task automatic close_f();
    wt(4);
    cs_n = 1'b1;
    sdi = ~sdi;
    wt(8);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      wt(4);
      sclk = 1'b1;
      wt(4);
      sclk = 1'b0;
    end
  endtask
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    open_f();
    for (int i = 15; i >= 0; i--) bit_x(w[i], r[i]);
    close_f();
  endtask
  // Frame-sync framing: data is taken on the falling clock edge.
  task automatic xfer_fs(input logic [15:0] w, output logic [15:0] r);
    frame_sync = 1'b0;
    wt(8);
    open_f();
    frame_sync = 1'b1;
    wt(8);
    frame_sync = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      wt(2);
      sdi = w[i];
      wt(2);
      sclk = 1'b1;
      wt(4);
      r[i] = sdo;
      sclk = 1'b0;
    end
    wt(2);
    frame_sync = 1'b1;
    close_f();
  endtask
  task automatic set_start(input logic v);
    async_conv_start_n = v;
  endtask
endmodule // adcs_host_model
`default_nettype wire
